// file: design/oag_pkg.sv
// Constants and types of the operand address generator
// Assumes a core clock at 250 MHz and a 16-bit data address space
package oag_pkg;
  localparam logic [15:0] SHORT_BASE = 16'hfe00;
  localparam logic [7:0] SHORT_WRAP_LIMIT = 8'h20;
  localparam logic [7:0] SFR_HIGH = 8'hff;
  localparam logic [7:0] SFR_HOLE_LO = 8'hd0;
  localparam logic [7:0] SFR_HOLE_HI = 8'hdf;
  localparam logic [15:0] SHORT_SFR_START = 16'hff00;
  localparam logic [15:0] RAM_LO = 16'hfe20;
  localparam logic [15:0] RAM_HI = 16'hfeff;
  localparam logic [7:0] OP_LOAD_ACC_PAIR2 = 8'h2b;
  localparam logic [1:0] PAIR_TWO_CODE = 2'h2;
  localparam logic [1:0] BASE_PAIR_CODE = 2'h3;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    MODE_DIRECT = 3'h0,
    MODE_SHORT = 3'h1,
    MODE_SFR = 3'h3,
    MODE_REG = 3'h2,
    MODE_INDIRECT = 3'h6,
    MODE_BASED = 3'h7,
    MODE_STACK = 3'h5,
    MODE_NONE = 3'h4
  } oag_mode_t;

  typedef enum logic [1:0] {
    SPACE_ANY = 2'h0,
    SPACE_RAM = 2'h1,
    SPACE_SFR = 2'h3
  } oag_space_t;
endpackage

// file: design/oag_pair_if.sv
// Register pair bundle between generator and pair selector
// Assumes one core clock domain
`timescale 1ns/1ps
interface oag_pair_if;
  logic [15:0] pairZero;
  logic [15:0] pairOne;
  logic [15:0] pairTwo;
  logic [15:0] basePair;
  logic [1:0] pairCode;
  logic [15:0] pairValue;
  modport gen (output pairZero, output pairOne, output pairTwo, output basePair, output pairCode, input pairValue);
  modport sel (input pairZero, input pairOne, input pairTwo, input basePair, input pairCode, output pairValue);
endinterface

// file: design/oag_pair_select.sv
// Register pair selector by pair code
// Assumes pair contents are stable in the decode cycle
`timescale 1ns/1ps
module oag_pair_select (
  oag_pair_if.sel pairBus
);
  // [RULE8] pair code select
  assign pairBus.pairValue = (pairBus.pairCode == 2'h0) ? pairBus.pairZero :
                             (pairBus.pairCode == 2'h1) ? pairBus.pairOne :
                             (pairBus.pairCode == 2'h2) ? pairBus.pairTwo : pairBus.basePair;
endmodule

// file: design/oag_address_gen.sv
// Operand effective address generator of the core
// Assumes decoder and register file share core_clk
// Notes on behaviour
// [RULE1] Direct: full 16-bit immediate is address
// [RULE2] Short direct reaches only FE20H..FF1FH
// [RULE3] Short bit 8 set only below 20H
// [RULE4] Word short direct needs even address
// [RULE5] Short window: RAM low, SFR high
// [RULE6] SFR: FFxx, FFD0H..FFDFH refused
// [RULE7] Byte register picked by 3-bit field
// [RULE8] Registers 0..7, pairs 0..3 by code
// [RULE9] Indirect uses pair two or base pair
// [RULE10] Based: zero-extended offset, carry dropped
// [RULE11] Stack accesses use stack pointer
// [RULE12] Stack accesses only internal RAM
// [RULE13] Opcode 2BH loads accumulator via pair two
// [RULE14] Address and select from decode cycle
`timescale 1ns/1ps
module oag_address_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Decoder side
  input wire logic decodeValid,
  input wire logic [2:0] addrMode,
  input wire logic [7:0] opcodeByte,
  input wire logic [15:0] fullImmediateAddress,
  input wire logic [7:0] operandByte,
  input wire logic [2:0] regField,
  input wire logic [1:0] registerPairOperand,
  input wire logic wordAccess,
  // Register file side
  input wire logic [15:0] pairZero,
  input wire logic [15:0] pairOne,
  input wire logic [15:0] pairTwo,
  input wire logic [15:0] basePair,
  input wire logic [15:0] stackPointerRegister,
  // Memory side
  output logic [15:0] effAddr,
  output logic memSelect,
  output logic [2:0] regSelect,
  output logic [1:0] space,
  output logic addrValid,
  output logic addrError,
  output logic loadAccPairTwo
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  oag_pair_if pairBus ();
  oag_pair_select pairSel (.pairBus(pairBus));

  // Inclusive range test shared by the error decodes
  function automatic logic inRange(input logic [15:0] value, input logic [15:0] lo, input logic [15:0] hi);
    return (value >= lo) && (value <= hi);
  endfunction

  oag_pkg::oag_mode_t mode;
  wire isLoad2b = (opcodeByte == oag_pkg::OP_LOAD_ACC_PAIR2);
  assign mode = isLoad2b ? oag_pkg::MODE_INDIRECT : oag_pkg::oag_mode_t'(addrMode);

  assign pairBus.pairZero = pairZero;
  assign pairBus.pairOne = pairOne;
  assign pairBus.pairTwo = pairTwo;
  assign pairBus.basePair = basePair;
  // [RULE9] [RULE13] indirect pair choice
  assign pairBus.pairCode = isLoad2b ? oag_pkg::PAIR_TWO_CODE :
                            (mode == oag_pkg::MODE_INDIRECT) ? {1'b1, registerPairOperand[0]} :
                            (mode == oag_pkg::MODE_BASED) ? oag_pkg::BASE_PAIR_CODE : registerPairOperand;

  // [RULE2] [RULE3] short window bit 8
  wire shortBit8 = (operandByte < oag_pkg::SHORT_WRAP_LIMIT);
  wire [15:0] shortAddr = oag_pkg::SHORT_BASE | {7'h00, shortBit8, operandByte};
  // [RULE6] SFR page and hole
  wire [15:0] sfrAddr = {oag_pkg::SFR_HIGH, operandByte};
  wire sfrHole = inRange({8'h00, operandByte}, {8'h00, oag_pkg::SFR_HOLE_LO}, {8'h00, oag_pkg::SFR_HOLE_HI});
  // [RULE10] zero-extend, carry dropped
  wire [16:0] basedSum = {1'b0, pairBus.pairValue} + {9'h000, operandByte};
  wire [15:0] basedAddr = basedSum[15:0];
  // [RULE12] stack limited to RAM
  wire stackOutRam = !inRange(stackPointerRegister, oag_pkg::RAM_LO, oag_pkg::RAM_HI);

  logic [15:0] addrNext;
  logic memNext;
  logic errNext;
  logic [1:0] spaceNext;
  always_comb begin
    addrNext = oag_pkg::ADDR_RESET;
    memNext = 1'b1;
    errNext = 1'b0;
    spaceNext = oag_pkg::SPACE_ANY;
    case (mode)
      // [RULE1] direct immediate
      oag_pkg::MODE_DIRECT: begin
        addrNext = fullImmediateAddress;
      end
      oag_pkg::MODE_SHORT: begin
        addrNext = shortAddr;
        // [RULE4] even word only
        errNext = wordAccess & operandByte[0];
        // [RULE5] RAM or SFR route
        spaceNext = (shortAddr >= oag_pkg::SHORT_SFR_START) ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_RAM;
      end
      oag_pkg::MODE_SFR: begin
        addrNext = sfrAddr;
        errNext = sfrHole;
        spaceNext = oag_pkg::SPACE_SFR;
      end
      // [RULE7] [RULE8] register operand
      oag_pkg::MODE_REG: begin
        memNext = 1'b0;
      end
      oag_pkg::MODE_INDIRECT: begin
        addrNext = pairBus.pairValue;
      end
      oag_pkg::MODE_BASED: begin
        addrNext = basedAddr;
      end
      // [RULE11] stack pointer address
      oag_pkg::MODE_STACK: begin
        addrNext = stackPointerRegister;
        errNext = stackOutRam;
        spaceNext = oag_pkg::SPACE_RAM;
      end
      default: begin
        memNext = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // [RULE14] registered at decode edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      effAddr <= oag_pkg::ADDR_RESET;
      memSelect <= 1'b0;
      regSelect <= 3'h0;
      space <= oag_pkg::SPACE_ANY;
      addrValid <= 1'b0;
      addrError <= 1'b0;
      loadAccPairTwo <= 1'b0;
    end else if (clkEn) begin
      effAddr <= addrNext;
      memSelect <= decodeValid & memNext;
      regSelect <= regField;
      space <= spaceNext;
      addrValid <= decodeValid;
      addrError <= decodeValid & errNext;
      loadAccPairTwo <= decodeValid & isLoad2b;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SHORT_BIT8: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE3]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SHORT) |=> (effAddr[8] == ($past(operandByte) < 8'h20)))
    else $error("short bit 8 wrong");
  AST_SHORT_RANGE: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE2]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SHORT) |=> (effAddr >= 16'hfe20 && effAddr <= 16'hff1f))
    else $error("short address outside window");
  AST_SFR_HOLE: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE6]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SFR) |=>
      (effAddr[15:8] == 8'hff && addrError == (effAddr[7:4] == 4'hd)))
    else $error("sfr address or hole flag wrong");
  AST_BASED_SUM: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE10]
    (clkEn && decodeValid && mode == oag_pkg::MODE_BASED) |=>
      (effAddr == 16'($past(basePair) + {8'h00, $past(operandByte)})))
    else $error("based sum wrong");
  AST_LOAD_2B: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE13]
    (clkEn && decodeValid && opcodeByte == 8'h2b) |=> (loadAccPairTwo && memSelect && effAddr == $past(pairTwo)))
    else $error("load via pair two wrong");
  AST_STACK_RAM: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE12]
    (clkEn && decodeValid && mode == oag_pkg::MODE_STACK) |=>
      (effAddr == $past(stackPointerRegister) && space == oag_pkg::SPACE_RAM))
    else $error("stack access wrong");
  AST_WORD_EVEN: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE4]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SHORT && wordAccess && operandByte[0]) |=> addrError)
    else $error("odd word address accepted");
  AST_REG_SELECT: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE7]
    (clkEn && decodeValid && mode == oag_pkg::MODE_REG) |=> (!memSelect && regSelect == $past(regField)))
    else $error("register select wrong");
  AST_DIRECT_ADDR: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE1]
    (clkEn && decodeValid && mode == oag_pkg::MODE_DIRECT) |=>
      (memSelect && effAddr == $past(fullImmediateAddress)))
    else $error("direct address wrong");
  AST_SHORT_SPACE: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE5]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SHORT) |=>
      (space == ((effAddr[15:8] == 8'hff) ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_RAM)))
    else $error("short window routing wrong");
  AST_WORD_EVEN_OK: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE4]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SHORT && wordAccess && !operandByte[0]) |=> !addrError)
    else $error("even word address refused");
  AST_SFR_SPACE: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE6]
    (clkEn && decodeValid && mode == oag_pkg::MODE_SFR) |=> (memSelect && space == oag_pkg::SPACE_SFR))
    else $error("sfr routing wrong");
  AST_INDIRECT_PAIR: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE9]
    (clkEn && decodeValid && mode == oag_pkg::MODE_INDIRECT && !isLoad2b) |=>
      (effAddr == ($past(registerPairOperand[0]) ? $past(basePair) : $past(pairTwo))))
    else $error("indirect pair wrong");
  AST_STACK_ERR: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE12]
    (clkEn && decodeValid && mode == oag_pkg::MODE_STACK) |=>
      (addrError == ($past(stackPointerRegister) < 16'hfe20 || $past(stackPointerRegister) > 16'hfeff)))
    else $error("stack range flag wrong");
  AST_LOAD_ONLY: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE13]
    (clkEn && !(decodeValid && opcodeByte == 8'h2b)) |=> !loadAccPairTwo)
    else $error("load flag without opcode");
  AST_NONE_IDLE: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE14]
    (clkEn && decodeValid && mode == oag_pkg::MODE_NONE) |=> (!memSelect && effAddr == 16'h0000))
    else $error("idle mode drove memory");
  AST_REG_NOADDR: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE7]
    (clkEn && decodeValid && mode == oag_pkg::MODE_REG) |=> (effAddr == 16'h0000 && !addrError))
    else $error("register operand drove address");

  // ----------------------------------------
  // Enable and valid checks
  // ----------------------------------------
  AST_VALID_NEXT: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE14]
    clkEn |=> (addrValid == $past(decodeValid)))
    else $error("valid not one cycle after decode");
  AST_FROZEN: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE14]
    !clkEn |=> ($stable(effAddr) && $stable(memSelect) && $stable(space) && $stable(addrValid)))
    else $error("outputs moved while disabled");
endmodule

// file: bench/oag_mem_model.sv
// Partner model: internal RAM only; SFR and other reads return a toggling pattern
// Assumes effAddr and space come from the generator each cycle
`timescale 1ns/1ps
module oag_mem_model (
  // Clock
  input wire logic core_clk,
  // Address from generator
  input wire logic [15:0] effAddr,
  input wire logic memSelect,
  input wire logic [1:0] space,
  // Read data
  output logic [7:0] rdData
);
  logic [7:0] ramArray [0:255];
  logic [7:0] lastData = 8'h00;
  // RAM preset to a known pattern
  initial begin
    for (int i = 0; i < 256; i++) begin
      ramArray[i] = 8'(i) ^ 8'h5a;
    end
  end
  // Non-RAM reads return a changing pattern, never stale data
  always @(posedge core_clk) begin
    lastData <= ~lastData;
    if (memSelect && space == oag_pkg::SPACE_RAM) begin
      rdData <= ramArray[effAddr[7:0]];
    end else begin
      rdData <= lastData;
    end
  end
endmodule

// file: bench/tb.sv
// Self-checking testbench of the operand address generator
// Assumes the design package and partner model compile first
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, decodeValid = 1'b0, wordAccess = 1'b0;
  logic [2:0] addrMode = 3'h4, regField = 3'h0, regSelect;
  logic [7:0] opcodeByte = 8'h00, operandByte = 8'h00, rdData;
  logic [1:0] registerPairOperand = 2'h0, space;
  logic [15:0] fullImmediateAddress = 16'h0000, effAddr, pairZero = 16'h0101, pairOne = 16'h0202;
  logic [15:0] pairTwo = 16'h1234, basePair = 16'hfff0, stackPointerRegister = 16'hfe80;
  logic memSelect, addrValid, addrError, loadAccPairTwo;
  int error_cnt = 0, tests_run = 0;
  logic [15:0] e;
  always #2 core_clk = ~core_clk;
  oag_address_gen DUT (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .decodeValid(decodeValid),
    .addrMode(addrMode), .opcodeByte(opcodeByte), .fullImmediateAddress(fullImmediateAddress),
    .operandByte(operandByte), .regField(regField), .registerPairOperand(registerPairOperand),
    .wordAccess(wordAccess), .pairZero(pairZero), .pairOne(pairOne), .pairTwo(pairTwo),
    .basePair(basePair), .stackPointerRegister(stackPointerRegister), .effAddr(effAddr),
    .memSelect(memSelect), .regSelect(regSelect), .space(space), .addrValid(addrValid),
    .addrError(addrError), .loadAccPairTwo(loadAccPairTwo));
  oag_mem_model partner (.core_clk(core_clk), .effAddr(effAddr), .memSelect(memSelect), .space(space),
    .rdData(rdData));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic issue(input logic [2:0] m, input logic [15:0] v, input logic [2:0] r, input logic w,
    input logic [7:0] opc);
    @(posedge core_clk);
    addrMode <= m;
    fullImmediateAddress <= v;
    operandByte <= v[7:0];
    regField <= r;
    registerPairOperand <= r[1:0];
    wordAccess <= w;
    opcodeByte <= opc;
    decodeValid <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_short();
    logic [7:0] tbl [4] = '{8'h20, 8'hff, 8'h00, 8'h1f};
    for (int i = 0; i < 4; i++) begin
      issue(oag_pkg::MODE_SHORT, {8'h00, tbl[i]}, 3'h0, 1'b0, 8'h00);
      e = {7'h7f, tbl[i] < 8'h20, tbl[i]};
      chk("short addr", e, effAddr);
      chk("short space", (e[15:8] == 8'hff) ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_RAM, space);
    end
    issue(oag_pkg::MODE_SHORT, 16'h0021, 3'h0, 1'b1, 8'h00);
    chk("odd word", 16'h0001, addrError);
    issue(oag_pkg::MODE_SHORT, 16'h0020, 3'h0, 1'b1, 8'h00);
    chk("even word", 16'h0000, addrError);
    $display("test short done");
  endtask
  task automatic test_sfr();
    logic [7:0] tbl [4] = '{8'hcf, 8'hd0, 8'hdf, 8'he0};
    for (int i = 0; i < 4; i++) begin
      issue(oag_pkg::MODE_SFR, {8'h00, tbl[i]}, 3'h0, 1'b0, 8'h00);
      chk("sfr addr", {8'hff, tbl[i]}, effAddr);
      chk("sfr hole", (tbl[i] >= 8'hd0 && tbl[i] <= 8'hdf), addrError);
    end
    $display("test sfr done");
  endtask
  task automatic test_misc();
    issue(oag_pkg::MODE_DIRECT, 16'hc3a5, 3'h0, 1'b0, 8'h00);
    chk("direct", 16'hc3a5, effAddr);
    chk("mem sel", 16'h0001, memSelect);
    chk("addr valid", 16'h0001, addrValid);
    for (int r = 0; r < 8; r++) begin
      issue(oag_pkg::MODE_REG, 16'h0000, r[2:0], 1'b0, 8'h00);
      chk("reg sel", r[15:0], regSelect);
      chk("reg not mem", 16'h0000, memSelect);
    end
    issue(oag_pkg::MODE_INDIRECT, 16'h0000, 3'h0, 1'b0, 8'h00);
    chk("indirect two", pairTwo, effAddr);
    issue(oag_pkg::MODE_INDIRECT, 16'h0000, 3'h1, 1'b0, 8'h00);
    chk("indirect base", basePair, effAddr);
    issue(oag_pkg::MODE_BASED, 16'h0020, 3'h0, 1'b0, 8'h00);
    chk("based carry", 16'h0010, effAddr);
    issue(oag_pkg::MODE_BASED, 16'h00ff, 3'h0, 1'b0, 8'h00);
    chk("based ext", 16'h00ef, effAddr);
    issue(oag_pkg::MODE_STACK, 16'h0000, 3'h0, 1'b0, 8'h00);
    chk("stack addr", 16'hfe80, effAddr);
    chk("stack ram", oag_pkg::SPACE_RAM, space);
    @(posedge core_clk);
    stackPointerRegister <= 16'hff00;
    #1;
    chk("stack ram data", 16'h00da, rdData);
    issue(oag_pkg::MODE_STACK, 16'h0000, 3'h0, 1'b0, 8'h00);
    chk("stack out", 16'h0001, addrError);
    issue(oag_pkg::MODE_NONE, 16'h0000, 3'h0, 1'b0, 8'h00);
    chk("none not mem", 16'h0000, memSelect);
    chk("none addr", 16'h0000, effAddr);
    issue(oag_pkg::MODE_INDIRECT, 16'h0000, 3'h1, 1'b0, 8'h2b);
    chk("load flag", 16'h0001, loadAccPairTwo);
    chk("load addr", pairTwo, effAddr);
    clkEn <= 1'b0;
    issue(oag_pkg::MODE_DIRECT, 16'h5555, 3'h0, 1'b0, 8'h00);
    chk("frozen", pairTwo, effAddr);
    chk("frozen flag", 16'h0001, loadAccPairTwo);
    $display("test misc done");
  endtask
  initial begin
    #20000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("reset addr", 16'h0000, effAddr);
    chk("reset valid", 16'h0000, addrValid);
    chk("reset mem sel", 16'h0000, memSelect);
    test_short();
    test_sfr();
    test_misc();
    results();
  end
endmodule
